// *** shared/mbcm_map.svh ***
// Register numbers, codes and timing counts of the
// command mailbox. Included by the design.
`ifndef MBCM_MAP_SVH
`define MBCM_MAP_SVH
`define MBCM_REG_CMD_BLOCK 16'h1f40
`define MBCM_REG_HANDLED 16'h1f54
`define MBCM_REG_STATUS 16'h1f55
`define MBCM_BLOCK_WORDS 5'd20
`define MBCM_FN_WRITE_MULTI 8'h10
`define MBCM_CMD_OPEN 16'h0388
`define MBCM_CMD_ENERGY_RST 16'hb688
`define MBCM_LEN_FIXED 16'h000a
`define MBCM_LEN_ONE_PARAM 16'h000c
`define MBCM_DEST 16'h1501
`define MBCM_PWD_TYPE 16'h0001
`define MBCM_ENERGY_ALL 16'h0200
`define MBCM_SETUP0 16'h1f53
`define MBCM_SETUP1 16'h1f54
`define MBCM_SETUP2 16'h1f55
`define MBCM_STATUS_BUSY 16'h0003
`define MBCM_RES_OK 8'h00
`define MBCM_RES_BAD_PWD 8'h01
`define MBCM_RES_LOCKED 8'h02
`define MBCM_RES_BAD_ARG 8'h10
`define MBCM_RES_UNSUPP 8'h13
`define MBCM_RES_TIMEOUT 8'h16
`define MBCM_RES_BAD_DEST 8'h18
`define MBCM_STATUS_DONE_HI 8'h00
`define MBCM_TIMEOUT_NS 1000000
`define MBCM_CLK_NS 8
`endif

// *** shared/mbcm_pkg.sv ***
// Types shared by the command mailbox and its environment.
// Assumes the Modbus layer has already parsed frames into word writes.
package mbcm_pkg;
   typedef struct packed {
      logic [15:0] addr;
      logic [15:0] data;
      logic first;
      logic last;
   } mbcm_wr_t;
   typedef enum logic [1:0] {
      MBCM_IDLE = 2'b00,
      MBCM_CHECK = 2'b01,
      MBCM_EXEC = 2'b10
   } mbcm_state_t;
endpackage

// *** verilog/mbcm_mailbox.sv ***
// Remote command mailbox: collects a 20-word command block, checks it,
// launches the action and reports handled code and result.
// Assumes a Modbus slave layer hands over register writes of one write
// request as a burst of word strobes marked first and last, and reads
// registers combinationally from the outputs below.
// The locking pad input is taken when a block is decoded, not when written.
// Only the handled code and status are kept; no read-back data buffer.
//
// What this block does
// - Parameter 512 (bit 9 only) clears all energy measurements.
// - Status shows 0x0003 while busy; master polls until it changes.
// - Handled command code goes to register 8020; mismatch means resend.
// - Result code sits in status low byte; zero is success.
// - Wrong password rejects the command with result 1.
// - Result 0x02 when locked, 0x13 unsupported, 0x16 timeout.
`timescale 1ns/10ps
`default_nettype none
`include "mbcm_map.svh"
module mbcm_mailbox #(
   parameter int TIMEOUT_CYC = `MBCM_TIMEOUT_NS / `MBCM_CLK_NS,
   // Default password value is arbitrary
   parameter logic [31:0] PASSWORD = 32'h30303030
) (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   // Register writes from the Modbus layer
   input wire logic wr_valid_i,
   input wire mbcm_pkg::mbcm_wr_t wr_i,
   input wire logic [7:0] wr_func_i,
   // Plant side
   input wire logic locked_i,
   output logic open_req_o,
   output logic energy_clr_o,
   input wire logic action_done_i,
   // Readable registers
   output logic [15:0] handled_code_o,
   output logic [15:0] status_o
);
   import mbcm_pkg::*;

   // The timeout counter below is 24 bits wide
   if (TIMEOUT_CYC < 1 || TIMEOUT_CYC > 32'h00ffffff) begin : g_bad_timeout
      $error("mbcm_mailbox: TIMEOUT_CYC out of range");
   end

   // Block words in the order the master writes them
   logic [15:0] blk [0:19];
   logic [4:0] wcnt;
   logic [4:0] next_wcnt;
   logic taking;
   logic addr_ok;
   logic good;
   logic full;
   mbcm_state_t state;
   logic [23:0] tcnt;
   logic [7:0] next_res;
   logic next_open;
   logic next_clr;

   // True when every word from 'from' up to word 16 is zero
   function automatic logic zeros(input int from);
      logic z;
      z = 1'b1;
      for (int i = 6; i <= 16; i++) begin
         if (i >= from && blk[i] != 16'h0000) begin
            z = 1'b0;
         end
      end
      return z;
   endfunction

   // Register number that word idx of the block must carry
   function automatic logic [15:0] block_addr(input logic [4:0] idx);
      return `MBCM_REG_CMD_BLOCK + {11'd0, idx};
   endfunction

   // Words are taken only while idle and before a finished block is seen,
   // so a quick follow-up burst cannot overwrite words under decode
   assign taking = wr_valid_i && state == MBCM_IDLE && !full;
   assign next_wcnt = wr_i.first ? 5'd1 : wcnt + 5'd1;
   assign addr_ok = wr_i.addr == block_addr(wcnt);

   // collect burst; function 16 from the block start, in order
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         wcnt <= 5'd0;
         good <= 1'b0;
         full <= 1'b0;
      end else begin
         full <= 1'b0;
         if (taking) begin
            wcnt <= next_wcnt;
            if (wr_i.first) begin
               good <= (wr_i.addr == block_addr(5'd0))
                  && (wr_func_i == `MBCM_FN_WRITE_MULTI);
            end else if (!addr_ok) begin
               good <= 1'b0;
            end
            if (wr_i.last) begin
               // Partial or overlong blocks are dropped silently: the master
               // only notices because the status never turns busy
               full <= next_wcnt == `MBCM_BLOCK_WORDS && good && addr_ok;
            end
         end
      end
   end

   // No reset on storage: a block is decoded only after all words landed
   always_ff @(posedge sys_clk_i) begin
      if (taking && wr_i.first) begin
         blk[0] <= wr_i.data;
      end else if (taking && wcnt < `MBCM_BLOCK_WORDS) begin
         blk[wcnt] <= wr_i.data;
      end
   end

   // Decode checks in priority order; only the first failing check is
   // reported, one result code per block
   always_comb begin
      next_res = `MBCM_RES_OK;
      next_open = 1'b0;
      next_clr = 1'b0;
      if (blk[17] != `MBCM_SETUP0 || blk[18] != `MBCM_SETUP1
            || blk[19] != `MBCM_SETUP2 || blk[2] != `MBCM_DEST) begin
         next_res = `MBCM_RES_BAD_DEST;
      // open code; energy reset code; unsupported
      end else if (blk[0] != `MBCM_CMD_OPEN
            && blk[0] != `MBCM_CMD_ENERGY_RST) begin
         next_res = `MBCM_RES_UNSUPP;
      end else if (blk[3] != `MBCM_PWD_TYPE
            || {blk[4], blk[5]} != PASSWORD) begin
         next_res = `MBCM_RES_BAD_PWD;
      end else if (locked_i) begin
         next_res = `MBCM_RES_LOCKED;
      end else if (blk[0] == `MBCM_CMD_OPEN) begin
         if (blk[1] != `MBCM_LEN_FIXED || !zeros(6)) begin
            next_res = `MBCM_RES_BAD_ARG;
         end else begin
            next_open = 1'b1;
         end
      end else if (blk[1] != `MBCM_LEN_ONE_PARAM || !zeros(7)
            || blk[6] != `MBCM_ENERGY_ALL) begin
         next_res = `MBCM_RES_BAD_ARG;
      end else begin
         next_clr = 1'b1;
      end
   end

   // Command sequencer
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state <= MBCM_IDLE;
         tcnt <= 24'd0;
         open_req_o <= 1'b0;
         energy_clr_o <= 1'b0;
         handled_code_o <= 16'h0000;
         status_o <= 16'h0000;
      end else begin
         open_req_o <= 1'b0;
         energy_clr_o <= 1'b0;
         case (state)
            MBCM_IDLE: begin
               if (full) begin
                  state <= MBCM_CHECK;
                  status_o <= `MBCM_STATUS_BUSY;
               end
            end
            MBCM_CHECK: begin
               // The code is updated for rejected blocks too, so the master
               // can tell which block a result belongs to
               // report handled code
               handled_code_o <= blk[0];
               if (next_res != `MBCM_RES_OK) begin
                  state <= MBCM_IDLE;
                  status_o <= {`MBCM_STATUS_DONE_HI, next_res};
               end else begin
                  state <= MBCM_EXEC;
                  tcnt <= 24'd0;
                  open_req_o <= next_open;
                  energy_clr_o <= next_clr;
               end
            end
            MBCM_EXEC: begin
               if (action_done_i) begin
                  state <= MBCM_IDLE;
                  status_o <= {`MBCM_STATUS_DONE_HI, `MBCM_RES_OK};
               end else if (tcnt == 24'(TIMEOUT_CYC - 1)) begin
                  // A plant that never answers would otherwise keep the
                  // status busy for good
                  // timeout result
                  state <= MBCM_IDLE;
                  status_o <= {`MBCM_STATUS_DONE_HI, `MBCM_RES_TIMEOUT};
               end else begin
                  tcnt <= tcnt + 24'd1;
               end
            end
            default: begin
               state <= MBCM_IDLE;
            end
         endcase
      end
   end
endmodule // mbcm_mailbox
`default_nettype wire

// *** verif/mbcm_chk.sv ***
// Port checker for the command mailbox.
// Assumes it is bound to the mailbox top module.
`timescale 1ns/10ps
`default_nettype none
module mbcm_chk import mbcm_pkg::*; (
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire logic wr_valid_i,
   input wire mbcm_pkg::mbcm_wr_t wr_i,
   input wire logic [7:0] wr_func_i,
   input wire logic locked_i,
   input wire logic open_req_o,
   input wire logic energy_clr_o,
   input wire logic action_done_i,
   input wire logic [15:0] handled_code_o,
   input wire logic [15:0] status_o
);
   wire logic blk_end = wr_valid_i && wr_i.last;
   wire logic pulse = open_req_o || energy_clr_o;
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i);
   a_open_code: assert property (open_req_o |-> status_o == 16'h0003 &&
      handled_code_o == 16'h0388) else $error("bad open");
   a_clear_code: assert property (energy_clr_o |-> status_o == 16'h0003 &&
      handled_code_o == 16'hb688) else $error("bad clear");
   a_busy_cause: assert property ($changed(status_o) && status_o == 16'h0003
      |-> $past(blk_end, 2)) else $error("busy without block");
   a_result_after: assert property ($changed(status_o) &&
      status_o != 16'h0003 |-> $past(status_o) == 16'h0003)
      else $error("result without busy");
   a_result_byte: assert property ($changed(status_o) |->
      status_o[15:8] == 8'h00 || status_o == 16'h0003) else $error("high byte");
   a_lock_code: assert property ($changed(status_o) &&
      status_o == 16'h0002 |-> $past(locked_i)) else $error("lock code");
   a_code_busy: assert property ($changed(handled_code_o) |->
      $past(status_o) == 16'h0003) else $error("code moved idle");
   a_done_ok: assert property (action_done_i && $past(pulse) |=>
      status_o == 16'h0000) else $error("no success");
   c_open: cover property (open_req_o);
   c_clear: cover property (energy_clr_o);
   c_late: cover property ($changed(status_o) && status_o == 16'h0016);
endmodule // mbcm_chk
bind mbcm_mailbox mbcm_chk u_chk (.sys_clk_i(sys_clk_i),
   .sys_rst_i(sys_rst_i), .wr_valid_i(wr_valid_i), .wr_i(wr_i),
   .wr_func_i(wr_func_i), .locked_i(locked_i), .open_req_o(open_req_o),
   .energy_clr_o(energy_clr_o), .action_done_i(action_done_i),
   .handled_code_o(handled_code_o), .status_o(status_o));
`default_nettype wire

// *** verif/mbcm_master.sv ***
// Modbus master model: builds, writes and polls command blocks.
// Assumes one register word is handed over per clock.
`timescale 1ns/10ps
`default_nettype none
module mbcm_master import mbcm_pkg::*; (
   input wire logic sys_clk_i,
   input wire logic [15:0] status_i,
   output logic wr_valid_o,
   output var mbcm_pkg::mbcm_wr_t wr_o,
   output logic [7:0] wr_func_o
);
   logic [15:0] blk [20];
   initial begin
      wr_valid_o = 1'b0;
      wr_o = '0;
      wr_func_o = 8'h00;
   end
   task automatic fill(logic [15:0] c, logic [31:0] p, logic [15:0] q);
      foreach (blk[i]) blk[i] = 16'h0000;
      blk[0] = c;
      blk[1] = (q == 16'h0000) ? 16'h000a : 16'h000c;
      blk[2] = 16'h1501;
      blk[3] = 16'h0001;
      blk[4] = p[31:16];
      blk[5] = p[15:0];
      blk[6] = q;
      blk[17] = 16'h1f53;
      blk[18] = 16'h1f54;
      blk[19] = 16'h1f55;
   endtask
   // one burst from the block start
   task automatic send(int n, logic [7:0] f);
      for (int i = 0; i < n; i++) begin
         @(posedge sys_clk_i);
         wr_valid_o <= 1'b1;
         wr_func_o <= f;
         wr_o <= '{16'h1f40 + i[15:0], blk[i], i == 0, i == n - 1};
      end
      @(posedge sys_clk_i);
      wr_valid_o <= 1'b0;
      // Released lines must not keep showing the last word
      wr_o <= ~wr_o;
   endtask
   task automatic wait_idle();
      repeat (2) @(negedge sys_clk_i);
      for (int k = 0; k < 200 && status_i === 16'h0003; k++)
         @(negedge sys_clk_i);
   endtask
endmodule // mbcm_master
`default_nettype wire

// *** verif/testbench.sv ***
// Self-checking bench for the command mailbox.
// Assumes the mailbox, checker and master model are compiled first.
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import mbcm_pkg::*;
   localparam logic [31:0] PWD = 32'h41426364;
   logic sys_clk_i, sys_rst_i, locked_i, action_done_i, answer, wr_valid_i;
   logic open_req_o, energy_clr_o;
   logic [7:0] wr_func_i;
   logic [15:0] handled_code_o, status_o;
   mbcm_wr_t wr_i;
   int num_errors = 0, check_count = 0, n_open = 0, n_clr = 0;
   mbcm_mailbox #(.TIMEOUT_CYC(16), .PASSWORD(PWD)) dut (
      .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .wr_valid_i(wr_valid_i),
      .wr_i(wr_i), .wr_func_i(wr_func_i), .locked_i(locked_i),
      .open_req_o(open_req_o), .energy_clr_o(energy_clr_o),
      .action_done_i(action_done_i), .handled_code_o(handled_code_o),
      .status_o(status_o));
   mbcm_master m (.sys_clk_i(sys_clk_i), .status_i(status_o),
      .wr_valid_o(wr_valid_i), .wr_o(wr_i), .wr_func_o(wr_func_i));
   // Plant answers one cycle after each action pulse, if told to
   always @(posedge sys_clk_i) begin
      action_done_i <= answer && (open_req_o || energy_clr_o);
      n_open <= n_open + (open_req_o ? 1 : 0);
      n_clr <= n_clr + (energy_clr_o ? 1 : 0);
   end
   function automatic logic [15:0] want(logic [15:0] c, logic [31:0] p,
      logic [15:0] q, logic l, logic a);
      if (c != 16'h0388 && c != 16'hb688) return 16'h0013;
      if (p != PWD) return 16'h0001;
      if (l) return 16'h0002;
      if (q != ((c == 16'h0388) ? 16'h0000 : 16'h0200)) return 16'h0010;
      return a ? 16'h0000 : 16'h0016;
   endfunction
   task automatic chk(logic [15:0] got, logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic run(logic [15:0] c, logic [31:0] p, logic [15:0] q,
      logic l, logic a);
      logic [15:0] e;
      logic go;
      int o0;
      int c0;
      e = want(c, p, q, l, a);
      go = e == 16'h0000 || e == 16'h0016;
      o0 = n_open;
      c0 = n_clr;
      @(posedge sys_clk_i);
      locked_i <= l;
      answer <= a;
      m.fill(c, p, q);
      m.send(20, 8'h10);
      m.wait_idle();
      chk(status_o, e);
      chk(handled_code_o, c);
      chk(16'(n_open - o0), {15'h0, go && c == 16'h0388});
      chk(16'(n_clr - c0), {15'h0, go && c == 16'hb688});
   endtask
   // One word of an otherwise good open block is spoilt
   task automatic bad(int w, logic [15:0] v, logic [15:0] e);
      @(posedge sys_clk_i);
      locked_i <= 1'b0;
      m.fill(16'h0388, PWD, 16'h0000);
      m.blk[w] = v;
      m.send(20, 8'h10);
      m.wait_idle();
      chk(status_o, e);
      chk(handled_code_o, 16'h0388);
   endtask
   task automatic results();
      if (num_errors == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      sys_clk_i = 1'b0;
      forever #4 sys_clk_i = ~sys_clk_i;
   end
   initial begin
      #100000;
      num_errors++;
      results();
   end
   initial begin
      logic [31:0] r;
      int k0;
      sys_rst_i = 1'b1;
      locked_i = 1'b0;
      answer = 1'b0;
      action_done_i = 1'b0;
      void'($urandom(32'hc11e));
      repeat (2) @(posedge sys_clk_i);
      sys_rst_i <= 1'b0;
      chk(status_o, 16'h0000);
      chk(handled_code_o, 16'h0000);
      run(16'h0388, PWD, 16'h0000, 1'b0, 1'b1);
      run(16'hb688, PWD, 16'h0200, 1'b0, 1'b1);
      run(16'hb688, PWD, 16'h0201, 1'b0, 1'b1);
      run(16'h0388, ~PWD, 16'h0000, 1'b0, 1'b1);
      run(16'h0388, PWD, 16'h0000, 1'b1, 1'b1);
      run(16'h0300, PWD, 16'h0000, 1'b0, 1'b1);
      run(16'h0388, PWD, 16'h0000, 1'b0, 1'b0);
      // Plant now answers, so a wrongly accepted block would end in 0000
      k0 = n_open + n_clr;
      answer <= 1'b1;
      m.send(19, 8'h10);
      m.wait_idle();
      m.send(20, 8'h06);
      m.wait_idle();
      chk(status_o, 16'h0016);
      chk(handled_code_o, 16'h0388);
      chk(16'(n_open + n_clr - k0), 16'h0000);
      bad(2, 16'h1502, 16'h0018);
      bad(19, 16'h0000, 16'h0018);
      bad(3, 16'h0000, 16'h0001);
      bad(16, 16'h0001, 16'h0010);
      for (int i = 0; i < 30; i++) begin
         r = $urandom;
         run(r[0] ? 16'h0388 : r[1] ? 16'hb688 : r[31:16], r[2] ? PWD : r,
            {6'h00, r[3], 9'h000}, r[4] & r[5], r[6]);
      end
      results();
   end
endmodule // testbench
`default_nettype wire
